// file: lcsf_top.v
// Limit registers, threshold comparators and sticky status flags of a
// power monitor's command set. Assumes an upstream SMBus engine that hands
// over one decoded command per cycle and returns read data to the host.
// Measurements arrive already sampled in this clock domain and hold
// between conversions; the alert pin is open-drain with a pull-up outside.
// Limits hold 16 bits as written, but readings are only MEAS_W bits wide,
// so an upper limit above full scale simply never flags.
//
// Function
// RULE1 - Temperature above overtemp fault limit sets fault flags and alert.
// RULE2 - Fault limit 0..0ffe is threshold, 0fff disables, resets to 0960.
// RULE3 - Temperature above overtemp warn limit sets warn flags and alert.
// RULE4 - Warn limit 0..0ffe is threshold, 0fff disables, resets to 07d0.
// RULE5 - Input voltage above overvoltage warn limit sets flags and alert.
// RULE6 - Overvoltage limit 0fff disables comparison and is the reset value.
// RULE7 - Input voltage below undervoltage warn limit sets flags and alert.
// RULE8 - Undervoltage limit 0 disables comparison and is the reset value.
// RULE9 - Four limit registers are read and written as whole words.
// RULE10 - Byte summary: bit3 undervolt, bit2 temp, bit1 comm, bit0 other.
// RULE11 - Word summary: byte in low bits, bit13 input, bit12 vendor.
// RULE12 - Startup conflict settled: vendor and other bits start at one.
// RULE13 - Flags stay set until cause is gone and clear command arrives.
// RULE14 - Input status: bit6 ov, bit5 uv, bit1 overcurrent, bit0 overpower.
// RULE15 - Temperature status: bit7 overtemp fault, bit6 overtemp warn.
// RULE16 - Host reads the three status bytes with byte reads.
// RULE17 - Clear command 03 clears flags and alert; alert returns if persisting.
// RULE18 - Measured temperature is the operand of both overtemp compares.
// RULE19 - Summary temp and input bits are ORs of their status flags.

`timescale 1ns/1ps

`include "lcsf_defines.vh"

module lcsf_top #(
    parameter MEAS_W = 12
) (
    input  wire              ref_clk_i,
    input  wire              rst_i,
    input  wire              cmd_valid_i,
    input  wire              cmd_write_i,
    input  wire [7:0]        cmd_code_i,
    input  wire [15:0]       cmd_wdata_i,
    input  wire [MEAS_W-1:0] temperature_i,
    input  wire [MEAS_W-1:0] vin_i,
    input  wire              input_overcurrent_warn_i,
    input  wire              input_overpower_warn_i,
    input  wire              comm_fault_i,
    input  wire              vendor_fault_i,
    output reg  [15:0]       rsp_data_o,
    output reg               rsp_valid_o,
    output reg               rsp_error_o,
    output reg               alert_out_o,
    output reg               alert_oe_n_o
);

    ////////////////////////////////////////////////////////////////////////
    // Command decode helpers

    // Codes outside the table fall through every decode and earn an error
    // True for a code that is one of the four word-wide limit registers
    function is_limit;
        input [7:0] code;
        begin
            is_limit = (code == `LCSF_CMD_OVERTEMP_FAULT_FLAG_LIM) ||
                       (code == `LCSF_CMD_OVERTEMP_WARN_FLAG_LIM)  ||
                       (code == `LCSF_CMD_VIN_OV_LIM)   ||
                       (code == `LCSF_CMD_VIN_UV_LIM);
        end
    endfunction

    // True for a read-only status code
    function is_status;
        input [7:0] code;
        begin
            is_status = (code == `LCSF_CMD_STATUS_BYTE)  ||
                        (code == `LCSF_CMD_STATUS_WORD)  ||
                        (code == `LCSF_CMD_STATUS_INPUT) ||
                        (code == `LCSF_CMD_STATUS_TEMP);
        end
    endfunction

    // Upper-limit compare; the all-ones code switches the compare off, so
    // a limit parked there can never flag, even at full-scale readings
    function over_limit;
        input [15:0] meas;
        input [15:0] lim;
        begin
            over_limit = (lim != `LCSF_HIGH_LIM_OFF) && (meas > lim);
        end
    endfunction

    // Lower-limit compare; zero switches it off, which also keeps a
    // zero reading from flagging while the monitor is still idle
    function under_limit;
        input [15:0] meas;
        input [15:0] lim;
        begin
            under_limit = (lim != `LCSF_LOW_LIM_OFF) && (meas < lim);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Storage

    // Limit words, kept at full width so read-back matches what was written
    reg  [15:0] overtemp_fault_flag_lim_q;
    reg  [15:0] overtemp_warn_flag_lim_q;
    reg  [15:0] vin_ov_lim_q;
    reg  [15:0] vin_uv_lim_q;

    // Sticky slots: one per cause plus the alert latch
    localparam FLAG_N      = 9;
    localparam FL_OVERTEMP_FAULT_FLAG = 0;
    localparam FL_OVERTEMP_WARN_FLAG  = 1;
    localparam FL_VIN_OV   = 2;
    localparam FL_VIN_UV   = 3;
    localparam FL_IN_OC    = 4;
    localparam FL_IN_OP    = 5;
    localparam FL_COMM     = 6;
    localparam FL_VENDOR   = 7;
    localparam FL_ALERT    = 8;

    wire [FLAG_N-1:0] flag_set;
    wire [FLAG_N-1:0] flag_init;
    wire [FLAG_N-1:0] flag_now;

    wire        wr_go;
    wire        rd_go;
    wire        clr_go;
    wire [15:0] temp_ext;
    wire [15:0] vin_ext;

    // Writes only reach the four limits; anything else written, except the clear code, is refused
    assign wr_go  = cmd_valid_i && cmd_write_i && is_limit(cmd_code_i);
    assign rd_go  = cmd_valid_i && !cmd_write_i &&
                    (is_limit(cmd_code_i) || is_status(cmd_code_i));
    // Send-byte carries no data; direction is not checked
    assign clr_go = cmd_valid_i && (cmd_code_i == `LCSF_CMD_CLEAR_FAULTS); // RULE17

    // Measurements widened to the limit width so compares see all 16 bits
    // Readings compare unsigned, as the limits do
    assign temp_ext = {{(16-MEAS_W){1'b0}}, temperature_i}; // RULE18
    assign vin_ext  = {{(16-MEAS_W){1'b0}}, vin_i};

    ////////////////////////////////////////////////////////////////////////
    // Threshold comparators; disable codes gate each compare

    wire overtemp_fault_flag_hit;
    wire overtemp_warn_flag_hit;
    wire vin_ov_hit;
    wire vin_uv_hit;
    wire any_hit;

    // A reading equal to a limit never flags; only strictly beyond it does
    assign overtemp_fault_flag_hit = over_limit(temp_ext, overtemp_fault_flag_lim_q);   // RULE1 RULE2
    assign overtemp_warn_flag_hit  = over_limit(temp_ext, overtemp_warn_flag_lim_q);    // RULE3 RULE4
    assign vin_ov_hit   = over_limit(vin_ext, vin_ov_lim_q);      // RULE5 RULE6
    assign vin_uv_hit   = under_limit(vin_ext, vin_uv_lim_q);     // RULE7 RULE8

    // Causes that raise the alert; comm and vendor events only set flags
    assign any_hit      = overtemp_fault_flag_hit | overtemp_warn_flag_hit | vin_ov_hit | vin_uv_hit |
                          input_overcurrent_warn_i | input_overpower_warn_i;

    ////////////////////////////////////////////////////////////////////////
    // Limit registers, written only as whole words
    // The word lands at one edge, so no half-written limit is ever compared

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            overtemp_fault_flag_lim_q <= `LCSF_OVERTEMP_FAULT_FLAG_RST; // RULE2
            overtemp_warn_flag_lim_q  <= `LCSF_OVERTEMP_WARN_FLAG_RST;  // RULE4
            vin_ov_lim_q   <= `LCSF_VIN_OV_RST;   // RULE6
            vin_uv_lim_q   <= `LCSF_VIN_UV_RST;   // RULE8
        end
        else if (wr_go)
        begin
            case (cmd_code_i) // RULE9
                `LCSF_CMD_OVERTEMP_FAULT_FLAG_LIM: overtemp_fault_flag_lim_q <= cmd_wdata_i;
                `LCSF_CMD_OVERTEMP_WARN_FLAG_LIM:  overtemp_warn_flag_lim_q  <= cmd_wdata_i;
                `LCSF_CMD_VIN_OV_LIM:   vin_ov_lim_q   <= cmd_wdata_i;
                `LCSF_CMD_VIN_UV_LIM:   vin_uv_lim_q   <= cmd_wdata_i;
                default:                vin_uv_lim_q   <= vin_uv_lim_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags: a set in the same cycle as the clear wins, so a still
    // present condition is flagged again at once

    // What sets each slot
    assign flag_set[FL_OVERTEMP_FAULT_FLAG] = overtemp_fault_flag_hit;               // RULE1
    assign flag_set[FL_OVERTEMP_WARN_FLAG]  = overtemp_warn_flag_hit;                // RULE3
    assign flag_set[FL_VIN_OV]   = vin_ov_hit;                 // RULE5
    assign flag_set[FL_VIN_UV]   = vin_uv_hit;                 // RULE7
    assign flag_set[FL_IN_OC]    = input_overcurrent_warn_i;
    assign flag_set[FL_IN_OP]    = input_overpower_warn_i;
    assign flag_set[FL_COMM]     = comm_fault_i;
    assign flag_set[FL_VENDOR]   = vendor_fault_i;
    assign flag_set[FL_ALERT]    = any_hit;                    // RULE17

    // Power-up values: only the vendor slot starts set
    assign flag_init = {`LCSF_FLAG_RST,
                        `LCSF_VENDOR_FLAG_RST,                 // RULE12
                        {(FLAG_N-2){`LCSF_FLAG_RST}}};

    // One identical sticky cell per slot. Only the clear command and reset
    // drop a slot; nothing times out on its own
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_N; gi = gi + 1)
        begin : g_flag
            reg flag_bit_q;

            always @(posedge ref_clk_i)
            begin
                if (rst_i)
                    flag_bit_q <= flag_init[gi];
                else
                    flag_bit_q <= (flag_bit_q & ~clr_go) | flag_set[gi]; // RULE13
            end

            assign flag_now[gi] = flag_bit_q;
        end
    endgenerate

    // Slots under their flag names, for the status builders below
    wire overtemp_fault_flag         = flag_now[FL_OVERTEMP_FAULT_FLAG];
    wire overtemp_warn_flag          = flag_now[FL_OVERTEMP_WARN_FLAG];
    wire input_overvolt_warn_flag    = flag_now[FL_VIN_OV];
    wire input_undervolt_warn_flag   = flag_now[FL_VIN_UV];
    wire input_overcurrent_warn_flag = flag_now[FL_IN_OC];
    wire input_overpower_warn_flag   = flag_now[FL_IN_OP];
    wire comm_fault_flag             = flag_now[FL_COMM];
    wire vendor_fault_flag           = flag_now[FL_VENDOR];
    wire alert_flag                  = flag_now[FL_ALERT];

    ////////////////////////////////////////////////////////////////////////
    // Status views, built from the sticky flags so they drop only when the flags clear

    reg  [7:0]  temp_status;
    reg  [7:0]  input_status;
    reg  [7:0]  summary_byte;
    reg  [15:0] summary_word;

    // Other-bit covers overvoltage, current, power and vendor causes, none
    // of which has a bit of its own in the byte
    wire        other_fault_flag;

    assign other_fault_flag = vendor_fault_flag | input_overvolt_warn_flag |
                              input_overcurrent_warn_flag | input_overpower_warn_flag;

    // Temperature byte; the unsupported low bits read zero
    always @*
    begin
        temp_status                    = 8'h00;
        temp_status[`LCSF_TS_OVERTEMP_FAULT_FLAG] = overtemp_fault_flag;         // RULE15
        temp_status[`LCSF_TS_OVERTEMP_WARN_FLAG]  = overtemp_warn_flag;          // RULE15
    end

    // Input byte; its fault bits are not built here and read zero
    always @*
    begin
        input_status                   = 8'h00;
        input_status[`LCSF_IN_OV_WARN] = input_overvolt_warn_flag;    // RULE14
        input_status[`LCSF_IN_UV_WARN] = input_undervolt_warn_flag;   // RULE14
        input_status[`LCSF_IN_OC_WARN] = input_overcurrent_warn_flag; // RULE14
        input_status[`LCSF_IN_OP_WARN] = input_overpower_warn_flag;   // RULE14
    end

    // Byte summary; the temperature bit is an OR so it drops with its sources
    always @*
    begin
        summary_byte                  = 8'h00;
        summary_byte[`LCSF_SB_VIN_UV] = input_undervolt_warn_flag;    // RULE10
        summary_byte[`LCSF_SB_TEMP]   = |temp_status;                 // RULE10 RULE19
        summary_byte[`LCSF_SB_COMM]   = comm_fault_flag;              // RULE10
        summary_byte[`LCSF_SB_OTHER]  = other_fault_flag;             // RULE10 RULE12
    end

    // Word summary: byte summary in the low half, input and vendor above
    always @*
    begin
        summary_word                  = {8'h00, summary_byte};        // RULE11
        summary_word[`LCSF_SW_INPUT]  = |input_status;                // RULE11 RULE19
        summary_word[`LCSF_SW_VENDOR] = vendor_fault_flag;            // RULE11 RULE12
    end

    ////////////////////////////////////////////////////////////////////////
    // Response path: a registered answer for reads and refused commands; limit writes and clears get none

    reg [15:0] rd_mux;

    // Byte-wide status registers answer in the low byte, upper byte zero
    // Decoded from the live code, so the answer shows flags as they stand
    always @*
    begin
        case (cmd_code_i)
            `LCSF_CMD_OVERTEMP_FAULT_FLAG_LIM: rd_mux = overtemp_fault_flag_lim_q;
            `LCSF_CMD_OVERTEMP_WARN_FLAG_LIM:  rd_mux = overtemp_warn_flag_lim_q;
            `LCSF_CMD_VIN_OV_LIM:   rd_mux = vin_ov_lim_q;
            `LCSF_CMD_VIN_UV_LIM:   rd_mux = vin_uv_lim_q;
            `LCSF_CMD_STATUS_BYTE:  rd_mux = {8'h00, summary_byte};  // RULE16
            `LCSF_CMD_STATUS_WORD:  rd_mux = summary_word;
            `LCSF_CMD_STATUS_INPUT: rd_mux = {8'h00, input_status};  // RULE16
            `LCSF_CMD_STATUS_TEMP:  rd_mux = {8'h00, temp_status};   // RULE16
            default:                rd_mux = 16'h0000;
        endcase
    end

    // Unknown codes and writes to status are refused with a one-cycle error.
    // A read of the clear code is taken as the clear itself, not refused.
    // Data is zero outside a read answer so a stale word never looks valid
    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            rsp_data_o  <= 16'h0000;
            rsp_valid_o <= 1'b0;
            rsp_error_o <= 1'b0;
        end
        else
        begin
            rsp_valid_o <= rd_go;
            rsp_error_o <= cmd_valid_i && !rd_go && !wr_go && !clr_go;
            rsp_data_o  <= rd_go ? rd_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Open-drain alert pin: drives low only while alert stands. Registered
    // once more so the pin comes from a flip-flop, at one cycle of latency;
    // the data bit stays low and only the enable moves

    always @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            alert_out_o  <= 1'b0;
            alert_oe_n_o <= 1'b1;
        end
        else
        begin
            alert_out_o  <= 1'b0;
            alert_oe_n_o <= ~alert_flag; // RULE17
        end
    end

endmodule

// file: lcsf_defines.vh
// Constants for the limit compare and status flag bank.
// Included by lcsf_top.v; holds definitions only.
`ifndef LCSF_DEFINES_VH
`define LCSF_DEFINES_VH

// Command codes
`define LCSF_CMD_CLEAR_FAULTS   8'h03
`define LCSF_CMD_OVERTEMP_FAULT_FLAG_LIM   8'h4f
`define LCSF_CMD_OVERTEMP_WARN_FLAG_LIM    8'h51
`define LCSF_CMD_VIN_OV_LIM     8'h57
`define LCSF_CMD_VIN_UV_LIM     8'h58
`define LCSF_CMD_STATUS_BYTE    8'h78
`define LCSF_CMD_STATUS_WORD    8'h79
`define LCSF_CMD_STATUS_INPUT   8'h7c
`define LCSF_CMD_STATUS_TEMP    8'h7d

// Limit reset values and disable codes
`define LCSF_OVERTEMP_FAULT_FLAG_RST       16'h0960
`define LCSF_OVERTEMP_WARN_FLAG_RST        16'h07d0
`define LCSF_VIN_OV_RST         16'h0fff
`define LCSF_VIN_UV_RST         16'h0000
`define LCSF_HIGH_LIM_OFF       16'h0fff
`define LCSF_LOW_LIM_OFF        16'h0000

// Summary bit positions
`define LCSF_SB_OTHER           0
`define LCSF_SB_COMM            1
`define LCSF_SB_TEMP            2
`define LCSF_SB_VIN_UV          3
`define LCSF_SW_VENDOR          12
`define LCSF_SW_INPUT           13

// Input status bit positions
`define LCSF_IN_OP_WARN         0
`define LCSF_IN_OC_WARN         1
`define LCSF_IN_UV_WARN         5
`define LCSF_IN_OV_WARN         6

// Temperature status bit positions
`define LCSF_TS_OVERTEMP_WARN_FLAG         6
`define LCSF_TS_OVERTEMP_FAULT_FLAG        7

// Sticky flag reset values
`define LCSF_VENDOR_FLAG_RST    1'b1
`define LCSF_FLAG_RST           1'b0

`endif

// file: lcsf_properties.sv
// Checker for the limit compare and status flag bank: answers and alert pin.
// Bound to every lcsf_top instance; sees only that module's ports.
`timescale 1ns/1ps

module lcsf_checker (
    input logic        ref_clk_i,
    input logic        rst_i,
    input logic        cmd_valid_i,
    input logic        cmd_write_i,
    input logic [7:0]  cmd_code_i,
    input logic        input_overcurrent_warn_i,
    input logic [15:0] rsp_data_o,
    input logic        rsp_valid_o,
    input logic        rsp_error_o,
    input logic        alert_oe_n_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // Decoded read and clear requests seen at the command port
    wire rd  = cmd_valid_i && !cmd_write_i;
    wire clr = cmd_valid_i && cmd_code_i == 8'h03;

    ////////////////////////////////////////////////////////////////////////////
    answer_has_cause_a: assert property (rsp_valid_o |-> $past(rd))
        else $error("answer without a read");
    limit_write_quiet_a: assert property (cmd_valid_i && cmd_write_i && cmd_code_i == 8'h4f
        |=> !rsp_valid_o && !rsp_error_o) else $error("limit write answered");
    status_write_refused_a: assert property (cmd_valid_i && cmd_write_i
        && cmd_code_i == 8'h78 |=> rsp_error_o) else $error("status write not refused");
    byte_top_zero_a: assert property (rd && cmd_code_i == 8'h78
        |=> rsp_valid_o && rsp_data_o[15:4] == 12'h000) else $error("byte summary bad");
    word_spare_zero_a: assert property (rd && cmd_code_i == 8'h79
        |=> rsp_data_o[15:14] == 2'h0 && rsp_data_o[11:4] == 8'h00) else $error("word bad");
    input_spare_zero_a: assert property (rd && cmd_code_i == 8'h7c
        |=> {rsp_data_o[15:7], rsp_data_o[4:2]} == 12'h000) else $error("input byte bad");
    temp_spare_zero_a: assert property (rd && cmd_code_i == 8'h7d
        |=> {rsp_data_o[15:8], rsp_data_o[5:0]} == 14'h0000) else $error("temp byte bad");
    overcurrent_alert_a: assert property (input_overcurrent_warn_i |-> ##2 !alert_oe_n_o)
        else $error("alert not raised");
    alert_sticky_a: assert property (!alert_oe_n_o && !clr && !$past(clr)
        |=> !alert_oe_n_o) else $error("alert dropped without clear");
endmodule

bind lcsf_top lcsf_checker chk (.ref_clk_i, .rst_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i,
    .input_overcurrent_warn_i, .rsp_data_o, .rsp_valid_o, .rsp_error_o, .alert_oe_n_o);

// file: lcsf_host_model.sv
// Host side model: issues decoded word, byte and send-byte commands.
// Assumes a command is taken at the first edge it is seen.
`timescale 1ns/1ps

module lcsf_host_model (
    input  logic        ref_clk_i,
    input  logic [15:0] rsp_data_i,
    input  logic        rsp_valid_i,
    input  logic        rsp_error_i,
    output logic        cmd_valid_o,
    output logic        cmd_write_o,
    output logic [7:0]  cmd_code_o,
    output logic [15:0] cmd_wdata_o
);
    // Idle at time zero
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_wdata_o = 16'h0000;
    end

    // One command, held until the taking edge; answer read 1 ns after that edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic [1:0] st);
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= w;
        cmd_code_o  <= c;
        cmd_wdata_o <= d;
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o  <= ~c;  // Released code and data lines never keep the last value; the write line does
        cmd_wdata_o <= ~d;
        #1;
        q  = rsp_data_i;
        st = {rsp_valid_i, rsp_error_i};
    endtask
endmodule

// file: lcsf_top_tb.sv
// Self-checking bench for lcsf_top with a host model on the command port.
// Telemetry inputs are driven here at the rising edge.
`timescale 1ns/1ps

module lcsf_top_tb;
    logic        ref_clk_i, rst_i, cmd_valid_i, cmd_write_i, rsp_valid_o, rsp_error_o;
    logic        input_overcurrent_warn_i, input_overpower_warn_i, comm_fault_i, vendor_fault_i;
    logic        alert_out_o, alert_oe_n_o;
    logic [7:0]  cmd_code_i;
    logic [15:0] cmd_wdata_i, rsp_data_o;
    logic [11:0] temperature_i, vin_i;
    int          failures = 0;
    int          checked = 0;

    lcsf_top uut (.ref_clk_i, .rst_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_wdata_i,
        .temperature_i, .vin_i, .input_overcurrent_warn_i, .input_overpower_warn_i,
        .comm_fault_i, .vendor_fault_i, .rsp_data_o, .rsp_valid_o, .rsp_error_o,
        .alert_out_o, .alert_oe_n_o);
    lcsf_host_model host (.ref_clk_i, .rsp_data_i(rsp_data_o), .rsp_valid_i(rsp_valid_o),
        .rsp_error_i(rsp_error_o), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
        .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // Bus helpers; st is {valid, error}
    task automatic rd(logic [7:0] c, logic [15:0] e, string n);
        logic [15:0] q;
        logic [1:0]  s;
        host.xfer(1'b0, c, 16'h0000, q, s);
        chk(n, e, q);
        chk("read status", 16'h0002, {14'h0, s});
    endtask
    task automatic wr(logic [7:0] c, logic [15:0] d, logic [1:0] e);
        logic [15:0] q;
        logic [1:0]  s;
        host.xfer(1'b1, c, d, q, s);
        chk("write data", 16'h0000, q);
        chk("write status", {14'h0, e}, {14'h0, s});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic s_reset;
        rd(8'h4f, 16'h0960, "fault limit");
        rd(8'h51, 16'h07d0, "warn limit");
        rd(8'h57, 16'h0fff, "ov limit");
        rd(8'h58, 16'h0000, "uv limit");
        rd(8'h79, 16'h1001, "reset word");
        wr(8'h78, 16'hffff, 2'b01);
        wr(8'h20, 16'h0000, 2'b01);
        wr(8'h03, 16'h0000, 2'b00);
        rd(8'h79, 16'h0000, "cleared word");
        chk("alert idle", 16'h0001, {15'h0, alert_oe_n_o});
        chk("alert data", 16'h0000, {15'h0, alert_out_o});
    endtask

    // Boundary equal to the limit must not flag; one above must
    task automatic s_temp;
        wr(8'h51, 16'h0100, 2'b00);
        rd(8'h51, 16'h0100, "warn limit back");
        @(posedge ref_clk_i) temperature_i <= 12'h100;
        rd(8'h7d, 16'h0000, "temp at limit");
        @(posedge ref_clk_i) temperature_i <= 12'h961;
        rd(8'h7d, 16'h00c0, "temp over both");
        rd(8'h78, 16'h0004, "byte temp");
        chk("alert temp", 16'h0000, {15'h0, alert_oe_n_o});
        wr(8'h4f, 16'h0fff, 2'b00);
        wr(8'h03, 16'h0000, 2'b00);
        rd(8'h7d, 16'h0040, "fault disabled");
        chk("alert kept", 16'h0000, {15'h0, alert_oe_n_o});
        @(posedge ref_clk_i) temperature_i <= 12'h000;
        rd(8'h7d, 16'h0040, "temp sticky");
        wr(8'h03, 16'h0000, 2'b00);
        rd(8'h78, 16'h0000, "byte cleared");
        chk("alert cleared", 16'h0001, {15'h0, alert_oe_n_o});
    endtask

    task automatic s_vin;
        @(posedge ref_clk_i) vin_i <= 12'h400;
        wr(8'h57, 16'h0800, 2'b00);
        wr(8'h58, 16'h0100, 2'b00);
        @(posedge ref_clk_i) vin_i <= 12'h800;
        rd(8'h7c, 16'h0000, "vin at limit");
        @(posedge ref_clk_i) vin_i <= 12'h801;
        rd(8'h7c, 16'h0040, "vin over");
        @(posedge ref_clk_i) vin_i <= 12'h0ff;
        rd(8'h7c, 16'h0060, "vin under");
        rd(8'h79, 16'h2009, "word vin");
        @(posedge ref_clk_i) vin_i <= 12'h400;
        wr(8'h03, 16'h0000, 2'b00);
        rd(8'h7c, 16'h0000, "vin cleared");
    endtask

    // Event inputs pulse one cycle; level inputs held
    task automatic s_misc;
        @(posedge ref_clk_i) {input_overcurrent_warn_i, input_overpower_warn_i} <= 2'b11;
        {comm_fault_i, vendor_fault_i} <= 2'b11;
        @(posedge ref_clk_i) {comm_fault_i, vendor_fault_i} <= 2'b00;
        rd(8'h7c, 16'h0003, "oc op");
        rd(8'h79, 16'h3003, "word misc");
        chk("alert oc", 16'h0000, {15'h0, alert_oe_n_o});
        @(posedge ref_clk_i) {input_overcurrent_warn_i, input_overpower_warn_i} <= 2'b00;
        wr(8'h03, 16'h0000, 2'b00);
        rd(8'h79, 16'h0000, "word end");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Clock, reset and main sequence
    initial
    begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        {temperature_i, vin_i} = 24'h000000;
        {input_overcurrent_warn_i, input_overpower_warn_i, comm_fault_i, vendor_fault_i} = 4'h0;
        rst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        s_reset();
        s_temp();
        s_vin();
        s_misc();
        complete_run();
    end
    // Hang guard
    initial
    begin
        #100000;
        failures++;
        complete_run();
    end
endmodule
